// [bench/spm_link_properties.sv]
module spm_link_properties (
   // clock and reset
   input  wire logic       ref_clk_in,
   input  wire logic       rst_n_in,
   // link signals
   input  wire logic       por,
   input  wire logic       hp_strobe,
   input  wire logic       dev_ctl_oe,
   input  wire logic       hst_ctl_oe,
   input  wire logic       dev_addr_oe,
   input  wire logic       dev_dhi_oe,
   input  wire logic       hst_dhi_oe,
   input  wire logic [2:0] dev_shr_oe,
   input  wire logic [2:0] hst_shr_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);

   a_por_quiet: assert property (por [*3] |-> !dev_ctl_oe && dev_shr_oe == 3'h0)
      else $error("device drives link in power-on reset");
   a_default_keep: assert property ($fell(por) |-> (dev_shr_oe == 3'h0) [*4])
      else $error("shared line left its default after reset");
   a_dev_addr: assert property (dev_ctl_oe |-> dev_addr_oe)
      else $error("device tenure without address drive");
   a_host_gap: assert property (hst_ctl_oe |=> !hst_ctl_oe)
      else $error("host tenure longer than one cycle");
   a_one_master: assert property (!(dev_ctl_oe && hst_ctl_oe))
      else $error("two masters drive control lines");
   a_hst_start: assert property ($rose(hst_ctl_oe) |-> !$past(dev_ctl_oe))
      else $error("host started while device held tenure");
   a_upper_free: assert property (hst_dhi_oe |-> !dev_dhi_oe)
      else $error("device drives upper data under host port");
   a_shr_owner: assert property ((dev_shr_oe & hst_shr_oe) == 3'h0)
      else $error("shared line driven from both ends");

   cover property (dev_ctl_oe ##1 dev_ctl_oe);
   cover property (hst_ctl_oe);
   cover property (hp_strobe && hst_dhi_oe);
   cover property (dev_shr_oe != 3'h0);
endmodule // spm_link_properties

// [bench/tb.sv]
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        ref_clk_in, rst_n_in, por_req_in, strap_in, hp_send_in, im_req_in, m_req_in;
   logic        f_burst, f_global, sys_data_oe_in, sw_wr_in, b;
   logic [31:0] hp_word_in, f_addr, mc_addr_in, sw_wdata_in, sw_rdata_out, ext_addr_out;
   logic [31:0] hp_data_out, obs_addr_out;
   logic [63:0] sys_data_in, sys_data_out;
   logic [4:0]  f_type, ext_type_out, obs_type_out;
   logic [3:0]  f_size, ext_size_out, obs_size_out;
   logic [2:0]  mc_baddr_in, obs_shr_out;
   logic [1:0]  sw_sel_in;
   logic [9:0]  irq_vec;
   logic [7:0]  irq_req_out;
   logic        ext_hit_out, ext_burst_out, ext_global_out, hp_valid_out, host_boot_out;
   logic        narrow_bus_out, host_port_on_out, cfg_loaded_out, dev_tenure_out;
   logic        obs_burst_out, obs_global_out, m_done_out;
   int          n_mismatch, num_checks;
   int          irq_map [10] = '{1, 1, 7, 7, 0, 4, 6, 2, 3, 5};

   spm_link_if spm_link_if_inst ();
   spm_dev_end spm_dev_end_inst (.link(spm_link_if_inst.dev), .ref_clk_in, .rst_n_in,
      .mc_addr_in, .mc_baddr_in, .im_req_in, .im_addr_in(f_addr), .im_type_in(f_type),
      .im_size_in(f_size), .im_burst_in(f_burst), .im_global_in(f_global), .sys_data_in,
      .sys_data_oe_in, .sys_data_out, .sw_wr_in, .sw_sel_in, .sw_wdata_in, .sw_rdata_out,
      .irq_req_out, .ext_hit_out, .ext_addr_out, .ext_type_out, .ext_size_out, .ext_burst_out,
      .ext_global_out, .hp_data_out, .hp_valid_out, .host_boot_out, .narrow_bus_out,
      .host_port_on_out, .cfg_loaded_out);
   spm_host_end spm_host_end_inst (.link(spm_link_if_inst.hst), .ref_clk_in, .rst_n_in,
      .por_req_in, .strap_in, .hp_send_in, .hp_word_in, .m_req_in, .m_addr_in(f_addr),
      .m_type_in(f_type), .m_size_in(f_size), .m_burst_in(f_burst), .m_global_in(f_global),
      .ext_int_req_1_n_in(~irq_vec[1:0]), .ext_int_req_7_n_in(~irq_vec[3:2]), .irq_other_n_in(~irq_vec[6:4]),
      .shr_drive_in(irq_vec[9:7]), .shr_irq_n_in(~irq_vec[9:7]), .dev_tenure_out,
      .obs_addr_out, .obs_type_out, .obs_size_out, .obs_burst_out, .obs_global_out,
      .obs_shr_out, .m_done_out);
   spm_link_properties spm_link_properties_inst (.ref_clk_in, .rst_n_in,
      .por(spm_link_if_inst.por), .hp_strobe(spm_link_if_inst.hp_strobe),
      .dev_ctl_oe(spm_link_if_inst.dev_ctl_oe), .hst_ctl_oe(spm_link_if_inst.hst_ctl_oe),
      .dev_addr_oe(spm_link_if_inst.dev_addr_oe), .dev_dhi_oe(spm_link_if_inst.dev_dhi_oe),
      .hst_dhi_oe(spm_link_if_inst.hst_dhi_oe), .dev_shr_oe(spm_link_if_inst.dev_shr_oe),
      .hst_shr_oe(spm_link_if_inst.hst_shr_oe));

   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk_in);
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [1:0] sel, input logic [31:0] d);
      sw_sel_in = sel;
      sw_wdata_in = d;
      sw_wr_in = 1'b1;
      cyc(1);
      sw_wr_in = 1'b0;
   endtask
   task automatic rd(input logic [1:0] sel, input logic [31:0] exp);
      sw_sel_in = sel;
      #1 chk(sw_rdata_out, exp);
   endtask
   task automatic por_seq(input logic s);
      strap_in = s;
      por_req_in = 1'b1;
      cyc(4);
      por_req_in = 1'b0;
      cyc(5);
   endtask
   task automatic hp_send(input logic [31:0] w);
      hp_word_in = w;
      hp_send_in = 1'b1;
      cyc(1);
      hp_send_in = 1'b0;
      cyc(1);
   endtask
   task automatic complete_run;
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      ref_clk_in = 1'b0;
      forever #50 ref_clk_in = ~ref_clk_in;
   end
   initial begin
      #100000;
      n_mismatch++;
      $display("ERROR %0t: timeout", $time);
      complete_run();
   end

   initial begin
      {rst_n_in, strap_in, hp_send_in, im_req_in, m_req_in, sw_wr_in, sys_data_oe_in} = '0;
      {f_burst, f_global, f_addr, f_type, f_size, hp_word_in, sw_wdata_in, sw_sel_in} = '0;
      {mc_addr_in, mc_baddr_in, sys_data_in, irq_vec} = '0;
      por_req_in = 1'b1;
      cyc(2);
      rst_n_in = 1'b1;
      por_seq(1'b0);
      chk({cfg_loaded_out, host_boot_out}, 2'b10);
      rd(spm_pkg::SEL_PINS, {22'h0, spm_pkg::PINS_RST});
      rd(spm_pkg::SEL_BUS_CTRL, 32'h2);
      for (int k = 0; k < 10; k++) begin
         irq_vec = 10'h1 << k;
         cyc(3);
         chk(irq_req_out, 8'h1 << irq_map[k]);
         irq_vec = '0;
         cyc(3);
      end
      wr(spm_pkg::SEL_PINS, 32'h149);
      irq_vec = 10'hf;
      cyc(3);
      chk(irq_req_out, 8'h82);
      irq_vec = '0;
      mc_baddr_in = 3'h7;
      cyc(4);
      chk(obs_shr_out, 3'h5);
      mc_baddr_in = 3'h0;
      cyc(4);
      chk(obs_shr_out, 3'h4);
      for (int k = 0; k < 2; k++) begin
         b = k[0];
         f_addr = {31'h2000_0020, b};
         f_type = {4'h5, b};
         f_size = {b, 3'h4};
         f_burst = b;
         f_global = !b;
         im_req_in = 1'b1;
         cyc(3);
         chk({dev_tenure_out, obs_addr_out}, {1'b1, f_addr});
         chk({obs_type_out, obs_size_out, obs_burst_out, obs_global_out},
             {f_type, f_size, f_burst, f_global});
         im_req_in = 1'b0;
         cyc(3);
         m_req_in = 1'b1;
         cyc(1);
         m_req_in = 1'b0;
         cyc(1);
         chk({m_done_out, ext_hit_out, ext_addr_out}, {2'b11, f_addr});
         chk({ext_type_out, ext_size_out, ext_burst_out, ext_global_out},
             {f_type, f_size, f_burst, f_global});
      end
      wr(spm_pkg::SEL_BUS_CTRL, 32'h0);
      mc_addr_in = 32'h1234_5678;
      cyc(3);
      chk(spm_link_if_inst.addr, mc_addr_in);
      wr(spm_pkg::SEL_BUS_CTRL, 32'h2);
      sys_data_in = 64'hfedc_ba98_7654_3210;
      sys_data_oe_in = 1'b1;
      cyc(3);
      chk(sys_data_out, sys_data_in);
      wr(spm_pkg::SEL_BUS_CTRL, 32'h3);
      cyc(3);
      chk(sys_data_out, {32'h0, sys_data_in[31:0]});
      hp_send(32'h5a5a_0001);
      chk(hp_valid_out, 1'b0);
      wr(spm_pkg::SEL_HOST_CTRL, 32'h1);
      hp_send(32'h5a5a_0002);
      chk({host_port_on_out, hp_valid_out, hp_data_out}, {2'b11, 32'h5a5a_0002});
      sys_data_oe_in = 1'b0;
      por_seq(1'b1);
      chk({cfg_loaded_out, host_boot_out}, 2'b01);
      wr(spm_pkg::SEL_HOST_CTRL, 32'h1);
      hp_send(32'h0000_0f03);
      chk({cfg_loaded_out, narrow_bus_out}, 2'b11);
      rd(spm_pkg::SEL_BUS_CTRL, 32'h3);
      rd(spm_pkg::SEL_HOST_CTRL, 32'h0);
      rd(spm_pkg::SEL_PINS, {22'h0, spm_pkg::PINS_RST});
      rd(spm_pkg::SEL_STATUS, 32'h6);
      complete_run();
   end
endmodule // tb

// [src/spm_dev_end.sv]
// Contract
// - host boot only if strap high during reset
// - host supplies config word over host port
// - narrow select gives upper lines to host
// - host port enable only after narrowing
// - eight internal interrupt requests from pins
// - reset default: two ext_int_req_1, two ext_int_req_7 lines
// - designer keeps one line per interrupt
// - external mode: drive and decode address bus
// - internal mode: memory controller drives address
// - master drives transfer type during tenure
// - master drives transfer size byte count
// - master asserts burst for four-quadword burst
// - initiator drives global; global means snoop
// - reserved lines: burst address or irq 2/3/5
// - line functions chosen by config registers
// - power-on reset input holds reset state
module spm_dev_end #(
   parameter logic [31:0] DEFAULT_CFG = spm_pkg::CFG_DEFAULT
) (
   // link
   spm_link_if.dev     link,
   // clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        rst_n_in,
   // memory controller
   input  wire logic [31:0] mc_addr_in,
   input  wire logic [2:0]  mc_baddr_in,
   // internal master
   input  wire logic        im_req_in,
   input  wire logic [31:0] im_addr_in,
   input  wire logic [4:0]  im_type_in,
   input  wire logic [3:0]  im_size_in,
   input  wire logic        im_burst_in,
   input  wire logic        im_global_in,
   // system data
   input  wire logic [63:0] sys_data_in,
   input  wire logic        sys_data_oe_in,
   output logic [63:0]      sys_data_out,
   // software registers
   input  wire logic        sw_wr_in,
   input  wire logic [1:0]  sw_sel_in,
   input  wire logic [31:0] sw_wdata_in,
   output logic [31:0]      sw_rdata_out,
   // core interrupt requests
   output logic [7:0]       irq_req_out,
   // decoded external access
   output logic             ext_hit_out,
   output logic [31:0]      ext_addr_out,
   output logic [4:0]       ext_type_out,
   output logic [3:0]       ext_size_out,
   output logic             ext_burst_out,
   output logic             ext_global_out,
   // host port
   output logic [31:0]      hp_data_out,
   output logic             hp_valid_out,
   // status
   output logic             host_boot_out,
   output logic             narrow_bus_out,
   output logic             host_port_on_out,
   output logic             cfg_loaded_out
);
   spm_pkg::spm_state_t state;
   spm_pkg::spm_state_t next_state;
   logic                boot;
   logic                next_boot;
   logic                narrow;
   logic                next_narrow;
   logic                ext_mode;
   logic                next_ext_mode;
   logic                hp_on;
   logic                next_hp_on;
   logic [9:0]          pins;
   logic [9:0]          next_pins;
   logic [31:0]         cfg;
   logic                run;

   function automatic logic [9:0] pins_of(input logic [31:0] w);
      pins_of = w[spm_pkg::CFG_SHR_LSB +: spm_pkg::PIN_W];
   endfunction

   assign run = (state == spm_pkg::SPM_ST_RUN);
   assign cfg = link.data[63:32];

   // reset, strap sampling, configuration load, software writes
   always_comb begin
      next_state    = state;
      next_boot     = boot;
      next_narrow   = narrow;
      next_ext_mode = ext_mode;
      next_hp_on    = hp_on;
      next_pins     = pins;
      unique case (state)
         spm_pkg::SPM_ST_POR: begin
            // boot choice uses the strap as last seen with power-on reset high
            if (!link.por) begin
               if (boot) begin
                  next_state = spm_pkg::SPM_ST_WAIT_CFG;
               end else begin
                  next_state    = spm_pkg::SPM_ST_RUN;
                  next_narrow   = DEFAULT_CFG[spm_pkg::CFG_NARROW_BIT];
                  next_ext_mode = DEFAULT_CFG[spm_pkg::CFG_EXTMODE_BIT];
                  next_pins     = pins_of(DEFAULT_CFG);
               end
            end
         end
         spm_pkg::SPM_ST_WAIT_CFG: begin
            if (link.hp_strobe) begin
               next_state    = spm_pkg::SPM_ST_RUN;
               next_narrow   = cfg[spm_pkg::CFG_NARROW_BIT];
               next_ext_mode = cfg[spm_pkg::CFG_EXTMODE_BIT];
               next_pins     = pins_of(cfg);
            end
         end
         spm_pkg::SPM_ST_RUN: begin
            if (sw_wr_in) begin
               unique case (sw_sel_in)
                  spm_pkg::SEL_BUS_CTRL: begin
                     next_narrow   = sw_wdata_in[spm_pkg::CFG_NARROW_BIT];
                     next_ext_mode = sw_wdata_in[spm_pkg::CFG_EXTMODE_BIT];
                  end
                  spm_pkg::SEL_HOST_CTRL: next_hp_on = sw_wdata_in[0];
                  spm_pkg::SEL_PINS:      next_pins  = sw_wdata_in[9:0];
                  spm_pkg::SEL_STATUS:    next_hp_on = hp_on;
               endcase
            end
         end
         default: next_state = spm_pkg::SPM_ST_POR;
      endcase
      if (link.por) begin
         next_state    = spm_pkg::SPM_ST_POR;
         next_boot     = link.strap;
         next_narrow   = spm_pkg::NARROW_RST;
         next_ext_mode = spm_pkg::EXTMODE_RST;
         next_hp_on    = spm_pkg::HPON_RST;
         next_pins     = spm_pkg::PINS_RST;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state    <= spm_pkg::SPM_ST_POR;
         boot     <= 1'b0;
         narrow   <= spm_pkg::NARROW_RST;
         ext_mode <= spm_pkg::EXTMODE_RST;
         hp_on    <= spm_pkg::HPON_RST;
         pins     <= spm_pkg::PINS_RST;
      end else begin
         state    <= next_state;
         boot     <= next_boot;
         narrow   <= next_narrow;
         ext_mode <= next_ext_mode;
         hp_on    <= next_hp_on;
         pins     <= next_pins;
      end
   end

   // link drive values
   logic        drv_ctl;
   logic        next_drv_ctl;
   logic        drv_addr;
   logic        next_drv_addr;
   logic [31:0] a_q;
   logic [31:0] next_a_q;
   logic [4:0]  tt_q;
   logic [3:0]  tsiz_q;
   logic        burst_q;
   logic        global_q;
   logic [2:0]  shr_oe;
   logic [2:0]  next_shr_oe;
   logic [2:0]  shr_q;
   logic [2:0]  next_shr_q;
   logic [2:0]  shr_irq;
   logic [7:0]  next_irq;
   logic [63:0] dq;
   logic        dlo_oe;
   logic        dhi_oe;

   genvar i;
   for (i = 0; i < spm_pkg::SHR_N; i++) begin : g_shr
      spm_pkg::spm_fn_t fn;
      assign fn = spm_pkg::spm_fn_t'(pins[2*i +: 2]);
      always_comb begin
         next_shr_oe[i] = 1'b0;
         next_shr_q[i]  = 1'b0;
         shr_irq[i]     = 1'b0;
         unique case (fn)
            spm_pkg::SPM_FN_BADDR: begin
               next_shr_oe[i] = run;
               next_shr_q[i]  = mc_baddr_in[i];
            end
            spm_pkg::SPM_FN_RSVD:  next_shr_oe[i] = run;
            default:               shr_irq[i] = run & ~link.shr[i];
         endcase
      end
   end

   always_comb begin
      next_drv_ctl  = run & ext_mode & im_req_in & ~(link.tenure & ~drv_ctl);
      next_drv_addr = next_drv_ctl | (run & ~ext_mode);
      next_a_q      = ext_mode ? im_addr_in : mc_addr_in;
      next_irq      = '0;
      next_irq[spm_pkg::EXT_INT_REQ_1_IDX] = |(~link.ext_int_req_1_n & pins[7:6]);
      next_irq[spm_pkg::EXT_INT_REQ_7_IDX] = |(~link.ext_int_req_7_n & pins[9:8]);
      next_irq[2] = shr_irq[0];
      next_irq[3] = shr_irq[1];
      next_irq[5] = shr_irq[2];
      next_irq[0] = ~link.irq_other_n[0];
      next_irq[4] = ~link.irq_other_n[1];
      next_irq[6] = ~link.irq_other_n[2];
      if (!run) begin
         next_irq = '0;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         drv_ctl     <= 1'b0;
         drv_addr    <= 1'b0;
         a_q         <= '0;
         tt_q        <= '0;
         tsiz_q      <= '0;
         burst_q     <= 1'b0;
         global_q    <= 1'b0;
         shr_oe      <= '0;
         shr_q       <= '0;
         irq_req_out <= '0;
         dq          <= '0;
         dlo_oe      <= 1'b0;
         dhi_oe      <= 1'b0;
      end else begin
         drv_ctl     <= next_drv_ctl;
         drv_addr    <= next_drv_addr;
         a_q         <= next_a_q;
         tt_q        <= im_type_in;
         tsiz_q      <= im_size_in;
         burst_q     <= im_burst_in;
         global_q    <= im_global_in;
         shr_oe      <= next_shr_oe;
         shr_q       <= next_shr_q;
         irq_req_out <= next_irq;
         dq          <= sys_data_in;
         dlo_oe      <= run & sys_data_oe_in;
         dhi_oe      <= run & sys_data_oe_in & ~narrow;
      end
   end

   assign link.dev_addr_o   = a_q;
   assign link.dev_addr_oe  = drv_addr;
   assign link.dev_tt_o     = tt_q;
   assign link.dev_tsiz_o   = tsiz_q;
   assign link.dev_burst_o  = burst_q;
   assign link.dev_global_o = global_q;
   assign link.dev_ctl_oe   = drv_ctl;
   assign link.dev_data_o   = dq;
   assign link.dev_dlo_oe   = dlo_oe;
   assign link.dev_dhi_oe   = dhi_oe;
   assign link.dev_shr_o    = shr_q;
   assign link.dev_shr_oe   = shr_oe;

   // capture of external tenures, host port words, readback
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ext_hit_out    <= 1'b0;
         ext_addr_out   <= '0;
         ext_type_out   <= '0;
         ext_size_out   <= '0;
         ext_burst_out  <= 1'b0;
         ext_global_out <= 1'b0;
         hp_data_out    <= '0;
         hp_valid_out   <= 1'b0;
         sys_data_out   <= '0;
      end else begin
         ext_hit_out  <= run & ext_mode & link.tenure & ~drv_ctl;
         sys_data_out <= link.data;
         hp_valid_out <= run & hp_on & narrow & link.hp_strobe;
         if (link.tenure & ~drv_ctl) begin
            ext_addr_out   <= link.addr;
            ext_type_out   <= link.tt;
            ext_size_out   <= link.tsiz;
            ext_burst_out  <= link.burst;
            ext_global_out <= link.global_snoop;
         end
         if (link.hp_strobe) begin
            hp_data_out <= cfg;
         end
      end
   end

   always_comb begin
      unique case (sw_sel_in)
         spm_pkg::SEL_BUS_CTRL:  sw_rdata_out = {30'h0, ext_mode, narrow};
         spm_pkg::SEL_HOST_CTRL: sw_rdata_out = {31'h0, hp_on};
         spm_pkg::SEL_PINS:      sw_rdata_out = {22'h0, pins};
         spm_pkg::SEL_STATUS:    sw_rdata_out = {29'h0, run, boot, drv_ctl};
      endcase
   end

   assign host_boot_out    = boot;
   assign narrow_bus_out   = narrow;
   assign host_port_on_out = hp_on;
   assign cfg_loaded_out   = run;
endmodule // spm_dev_end

// [src/spm_host_end.sv]
module spm_host_end (
   // link
   spm_link_if.hst     link,
   // clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        rst_n_in,
   // reset and strap
   input  wire logic        por_req_in,
   input  wire logic        strap_in,
   // host port
   input  wire logic        hp_send_in,
   input  wire logic [31:0] hp_word_in,
   // bus master request
   input  wire logic        m_req_in,
   input  wire logic [31:0] m_addr_in,
   input  wire logic [4:0]  m_type_in,
   input  wire logic [3:0]  m_size_in,
   input  wire logic        m_burst_in,
   input  wire logic        m_global_in,
   // interrupt lines, active low, and active-high shared line drive enables
   input  wire logic [1:0]  ext_int_req_1_n_in,
   input  wire logic [1:0]  ext_int_req_7_n_in,
   input  wire logic [2:0]  irq_other_n_in,
   input  wire logic [2:0]  shr_drive_in,
   input  wire logic [2:0]  shr_irq_n_in,
   // observation
   output logic             dev_tenure_out,
   output logic [31:0]      obs_addr_out,
   output logic [4:0]       obs_type_out,
   output logic [3:0]       obs_size_out,
   output logic             obs_burst_out,
   output logic             obs_global_out,
   output logic [2:0]       obs_shr_out,
   output logic             m_done_out
);
   logic        por_q;
   logic        strap_q;
   logic        hp_q;
   logic [31:0] hp_w;
   logic        ctl;
   logic        next_ctl;
   logic [31:0] a_q;
   logic [4:0]  tt_q;
   logic [3:0]  ts_q;
   logic        b_q;
   logic        g_q;
   logic [1:0]  i1;
   logic [1:0]  i7;
   logic [2:0]  io;
   logic [2:0]  so;
   logic [2:0]  sq;

   // one-cycle tenure, only while the device holds no tenure
   assign next_ctl = m_req_in & ~link.dev_ctl_oe & ~ctl;

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         por_q   <= 1'b1;
         strap_q <= 1'b0;
         hp_q    <= 1'b0;
         hp_w    <= '0;
         ctl     <= 1'b0;
         a_q     <= '0;
         tt_q    <= '0;
         ts_q    <= '0;
         b_q     <= 1'b0;
         g_q     <= 1'b0;
         i1      <= 2'h3;
         i7      <= 2'h3;
         io      <= 3'h7;
         so      <= '0;
         sq      <= 3'h7;
      end else begin
         por_q   <= por_req_in;
         strap_q <= strap_in;
         hp_q    <= hp_send_in;
         hp_w    <= hp_word_in;
         ctl     <= next_ctl;
         a_q     <= m_addr_in;
         tt_q    <= m_type_in;
         ts_q    <= m_size_in;
         b_q     <= m_burst_in;
         g_q     <= m_global_in;
         i1      <= ext_int_req_1_n_in;
         i7      <= ext_int_req_7_n_in;
         io      <= irq_other_n_in;
         so      <= shr_drive_in;
         sq      <= shr_irq_n_in;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         dev_tenure_out <= 1'b0;
         obs_addr_out   <= '0;
         obs_type_out   <= '0;
         obs_size_out   <= '0;
         obs_burst_out  <= 1'b0;
         obs_global_out <= 1'b0;
         obs_shr_out    <= 3'h7;
         m_done_out     <= 1'b0;
      end else begin
         dev_tenure_out <= link.dev_ctl_oe;
         obs_addr_out   <= link.addr;
         obs_shr_out    <= link.shr;
         m_done_out     <= ctl;
         if (link.dev_ctl_oe) begin
            obs_type_out   <= link.tt;
            obs_size_out   <= link.tsiz;
            obs_burst_out  <= link.burst;
            obs_global_out <= link.global_snoop;
         end
      end
   end

   assign link.por          = por_q;
   assign link.strap        = strap_q;
   assign link.hp_strobe    = hp_q;
   assign link.hst_dhi_o    = hp_w;
   assign link.hst_dhi_oe   = hp_q;
   assign link.hst_addr_o   = a_q;
   assign link.hst_addr_oe  = ctl;
   assign link.hst_ctl_oe   = ctl;
   assign link.hst_tt_o     = tt_q;
   assign link.hst_tsiz_o   = ts_q;
   assign link.hst_burst_o  = b_q;
   assign link.hst_global_o = g_q;
   assign link.ext_int_req_1_n       = i1;
   assign link.ext_int_req_7_n       = i7;
   assign link.irq_other_n  = io;
   assign link.hst_shr_oe   = so;
   assign link.hst_shr_o    = sq;
endmodule // spm_host_end

// [src/spm_link_if.sv]
interface spm_link_if;
   logic [31:0] dev_addr_o;
   logic [31:0] hst_addr_o;
   logic [31:0] addr;
   logic        dev_addr_oe;
   logic        hst_addr_oe;
   logic [4:0]  dev_tt_o;
   logic [4:0]  hst_tt_o;
   logic [4:0]  tt;
   logic [3:0]  dev_tsiz_o;
   logic [3:0]  hst_tsiz_o;
   logic [3:0]  tsiz;
   logic        dev_burst_o;
   logic        hst_burst_o;
   logic        burst;
   logic        dev_global_o;
   logic        hst_global_o;
   logic        global_snoop;
   logic        dev_ctl_oe;
   logic        hst_ctl_oe;
   logic        tenure;
   logic [63:0] dev_data_o;
   logic        dev_dlo_oe;
   logic        dev_dhi_oe;
   logic [31:0] hst_dhi_o;
   logic        hst_dhi_oe;
   logic [63:0] data;
   logic [2:0]  dev_shr_o;
   logic [2:0]  dev_shr_oe;
   logic [2:0]  hst_shr_o;
   logic [2:0]  hst_shr_oe;
   logic [2:0]  shr;
   logic [1:0]  ext_int_req_1_n;
   logic [1:0]  ext_int_req_7_n;
   logic [2:0]  irq_other_n;
   logic        strap;
   logic        por;
   logic        hp_strobe;

   // undriven lines settle low, shared lines high
   assign addr  = dev_addr_oe ? dev_addr_o : (hst_addr_oe ? hst_addr_o : '0);
   assign tt    = dev_ctl_oe ? dev_tt_o : (hst_ctl_oe ? hst_tt_o : '0);
   assign tsiz  = dev_ctl_oe ? dev_tsiz_o : (hst_ctl_oe ? hst_tsiz_o : '0);
   assign burst = dev_ctl_oe ? dev_burst_o : (hst_ctl_oe & hst_burst_o);
   assign global_snoop = dev_ctl_oe ? dev_global_o : (hst_ctl_oe & hst_global_o);
   assign tenure = dev_ctl_oe | hst_ctl_oe;
   assign data[31:0]  = dev_dlo_oe ? dev_data_o[31:0] : '0;
   assign data[63:32] = dev_dhi_oe ? dev_data_o[63:32] : (hst_dhi_oe ? hst_dhi_o : '0);

   genvar i;
   for (i = 0; i < 3; i++) begin : g_shr
      assign shr[i] = dev_shr_oe[i] ? dev_shr_o[i] : (hst_shr_oe[i] ? hst_shr_o[i] : 1'b1);
   end

   modport dev (
      input  addr, tt, tsiz, burst, global_snoop, tenure, data, shr,
      input  ext_int_req_1_n, ext_int_req_7_n, irq_other_n, strap, por, hp_strobe,
      output dev_addr_o, dev_addr_oe, dev_tt_o, dev_tsiz_o, dev_burst_o, dev_global_o,
      output dev_ctl_oe, dev_data_o, dev_dlo_oe, dev_dhi_oe, dev_shr_o, dev_shr_oe
   );
   modport hst (
      input  addr, tt, tsiz, burst, global_snoop, tenure, data, shr,
      input  dev_ctl_oe, dev_addr_oe,
      output hst_addr_o, hst_addr_oe, hst_tt_o, hst_tsiz_o, hst_burst_o, hst_global_o,
      output hst_ctl_oe, hst_dhi_o, hst_dhi_oe, hst_shr_o, hst_shr_oe,
      output ext_int_req_1_n, ext_int_req_7_n, irq_other_n, strap, por, hp_strobe
   );
endinterface

// [src/spm_pkg.sv]
package spm_pkg;
   // link widths
   localparam int ADDR_W = 32;
   localparam int TT_W   = 5;
   localparam int TSIZ_W = 4;
   localparam int DATA_W = 64;
   localparam int HALF_W = 32;
   localparam int IRQ_N  = 8;
   localparam int SHR_N  = 3;
   localparam int DUP_N  = 2;
   localparam int OTH_N  = 3;
   localparam int WORD_W = 32;

   // configuration word layout
   localparam int CFG_NARROW_BIT  = 0;
   localparam int CFG_EXTMODE_BIT = 1;
   localparam int CFG_SHR_LSB     = 2;
   localparam int CFG_EXT_INT_REQ_1_LSB    = 8;
   localparam int CFG_EXT_INT_REQ_7_LSB    = 10;
   localparam int PIN_W           = 10;

   // default word used when the strap is low
   localparam logic [31:0] CFG_DEFAULT = 32'h0000_0f02;

   // register reset values
   localparam logic       NARROW_RST  = 1'b0;
   localparam logic       EXTMODE_RST = 1'b1;
   localparam logic       HPON_RST    = 1'b0;
   localparam logic [9:0] PINS_RST    = 10'h3c0;

   // software register selectors
   localparam logic [1:0] SEL_BUS_CTRL  = 2'h0;
   localparam logic [1:0] SEL_HOST_CTRL = 2'h1;
   localparam logic [1:0] SEL_PINS      = 2'h2;
   localparam logic [1:0] SEL_STATUS    = 2'h3;

   // interrupt request indices
   localparam int EXT_INT_REQ_1_IDX = 1;
   localparam int EXT_INT_REQ_7_IDX = 7;

   // shared line function codes, 2'b11 is illegal and acts as irq
   typedef enum logic [1:0] {
      SPM_FN_IRQ   = 2'b00,
      SPM_FN_BADDR = 2'b01,
      SPM_FN_RSVD  = 2'b10
   } spm_fn_t;

   typedef enum logic [1:0] {
      SPM_ST_POR      = 2'b00,
      SPM_ST_WAIT_CFG = 2'b01,
      SPM_ST_RUN      = 2'b10
   } spm_state_t;
endpackage
